// file: common/fcs_pkg.sv
// Purpose: shared constants and types of the flash rewrite sequencer
// Assumes: 16-bit command words, 32-bit register bus
// Notes: register offsets are byte addresses, field positions are bit numbers
package fcs_pkg;
  // command codes, low byte only
  localparam logic [7:0] CMD_RD_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_RD_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_BLK_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_ALL = 8'hA7;
  localparam logic [7:0] CMD_LOCK_PROG = 8'h77;
  localparam logic [7:0] CMD_LOCK_READ = 8'h71;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  // register offsets
  localparam logic [11:0] OFS_CTRL_PRI = 12'h000;
  localparam logic [11:0] OFS_CTRL_SEC = 12'h004;
  // flash_control_primary fields
  localparam int PRI_READY_BIT = 0;
  localparam int PRI_ENABLE_BIT = 1;
  localparam int PRI_LOCKDIS_BIT = 2;
  localparam int PRI_PERR_BIT = 6;
  localparam int PRI_EERR_BIT = 7;
  // flash_control_secondary fields
  localparam int SEC_MODE_BIT = 1;
  localparam int SEC_LOCKRES_BIT = 6;
  // status_byte fields
  localparam int ST_READY_BIT = 7;
  localparam int ST_EERR_BIT = 5;
  localparam int ST_PERR_BIT = 4;
  // values after reset, erased word, erase-all last block, control bit count
  localparam logic RST_ERR = 1'b0;
  localparam logic RST_LOCK_RES = 1'b0;
  localparam logic RST_STATUS_MODE = 1'b0;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [3:0] LAST_ALL_BLK = 4'hC;
  localparam int CTRL_BITS = 3;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT2, ST_CHECK, ST_VERIFY, ST_RUN, ST_NEXT
  } fcs_state_e;
  typedef enum logic [1:0] {
    OP_PROGRAM, OP_ERASE, OP_LOCK_PROG, OP_LOCK_READ
  } fcs_op_e;
endpackage

// file: logic/fcs_ctrl_bits.sv
// Purpose: rewrite enable, lock disable and mode select bits
// Assumes: one write strobe per register bus write
// Notes: a bit goes to 1 only after a 0 written by the write just before
`timescale 1ns/1ps
module fcs_ctrl_bits (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write side
  input wire logic any_wr,
  input wire logic [fcs_pkg::CTRL_BITS-1:0] wr_hit,
  input wire logic [fcs_pkg::CTRL_BITS-1:0] wbit,
  input wire logic intervene,
  input wire logic nmi_high,
  input wire logic force_clr,
  // bit values, 0 enable, 1 lock disable, 2 mode select
  output logic [fcs_pkg::CTRL_BITS-1:0] q
);
  import fcs_pkg::*;

  logic [CTRL_BITS-1:0] q_r;
  logic [CTRL_BITS-1:0] q_nxt;
  logic [CTRL_BITS-1:0] armed_r;
  logic [CTRL_BITS-1:0] armed_nxt;
  wire en_cleared = wr_hit[0] & ~wbit[0];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  //////////////////////////////////////////////////////////////////////
  genvar i;
  generate
    for (i = 0; i < CTRL_BITS; i++) begin : g_bit
      // the other two bits need rewrite enable already set
      wire allowed = (i == 0) ? 1'b1 : q_r[0];
      wire set_ok = armed_r[i] & nmi_high & allowed;
      // an interrupt or dma between the two writes cancels the arming
      assign armed_nxt[i] = intervene ? 1'b0 :
                            any_wr ? (wr_hit[i] & ~wbit[i]) :
                            armed_r[i]; // see [R16]
      always_comb begin
        q_nxt[i] = q_r[i];
        if (wr_hit[i]) begin
          q_nxt[i] = wbit[i] & (set_ok | q_r[i]); // see [R16]
        end
        if ((i == 2) && en_cleared) begin
          q_nxt[i] = 1'b0;
        end
        if (force_clr) begin
          q_nxt[i] = 1'b0; // see [R17]
        end
      end
      a_set_needs_zero: assert property (
        $rose(q_r[i]) |-> $past(armed_r[i]) && !$past(force_clr))
        else $error("control bit set without a preceding zero write");
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
      armed_r <= '0;
    end else begin
      q_r <= q_nxt;
      armed_r <= armed_nxt;
    end
  end

  assign q = q_r;
endmodule

// file: logic/fcs_sequencer.sv
// Purpose: command sequencer for cpu rewriting of the on-chip flash
// Assumes: array reports done with a one-cycle pulse on pclk
// Notes: control bits live on apb; commands arrive on the rom port
//
// What the document requires of this block and of its software
// [R1] commands are 16-bit words at even addresses; only the low byte counts
// [R2] FFh selects read array mode, which persists until another command
// [R3] after 70h, reads of any even address return the status byte
// [R4] software must not read status in the flash-executed mode
// [R5] 50h clears both error flags in control register and status byte
// [R6] 40h then data to the same even address starts auto program
// [R7] ready reads 0 throughout any auto program or erase
// [R8] after auto program, program error is 1 on failure, 0 on success
// [R9] an already programmed word cannot be programmed again before erase
// [R10] in ram-executed mode program start forces status mode, ready low
// [R11] 20h then D0h at a block's top even address erases that block
// [R12] after auto erase, erase error is 1 on failure, 0 on success
// [R13] in ram-executed mode erase forces status mode until FFh or 71h
// [R14] A7h then D0h erases blocks 0 to 12 in turn, never block A
// [R15] software must not erase all from flash while its block is open
// [R16] setting a control bit needs a 0 write immediately before the 1
// [R17] nmi, or watchdog in ram mode, clears control and aborts operation
// [R18] software sets clock to at most 10 MHz and wait states first
// [R19] software must not start dma while ready is 0 in flash mode
// [R20] software clears rewrite enable before wait or stop mode
// [R21] no program, erase or lock commands while the main clock stops
// [R22] 77h then D0h at a block's top address locks that block
// [R23] 71h then D0h reports lock state: 1 unlocked, 0 locked
// [R24] status byte: ready bit 7, erase error bit 5, program error bit 4
// [R25] while an error flag is set, program and erase commands are refused
// [R26] status reads drive the upper eight data bits to zero
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module fcs_sequencer #(
  parameter int AW = 20,
  parameter int BLK_W = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu access to user rom
  input wire logic rom_wr,
  input wire logic rom_rd,
  input wire logic [AW-1:0] rom_addr,
  input wire logic [15:0] rom_wdata,
  output logic [15:0] rom_rdata,
  // flash array
  output logic [AW-1:0] arr_addr,
  input wire logic [15:0] arr_rdata,
  input wire logic [BLK_W-1:0] arr_addr_blk,
  output logic [BLK_W-1:0] arr_blk,
  input wire logic arr_locked,
  output logic arr_start,
  output fcs_pkg::fcs_op_e arr_kind,
  output logic [15:0] arr_wdata,
  input wire logic arr_done,
  input wire logic arr_fail,
  input wire logic arr_lock_bit,
  output logic arr_abort,
  // system events
  input wire logic nmi_req,
  input wire logic wdt_req,
  input wire logic irq_dma_event,
  input wire logic nmi_pin_n
);
  import fcs_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // state
  fcs_state_e state_r, state_nxt;
  fcs_op_e kind_r, kind_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [AW-1:0] op_addr_r, op_addr_nxt;
  logic [15:0] op_data_r, op_data_nxt;
  logic [BLK_W-1:0] blk_r, blk_nxt;
  logic word_ok_r, word_ok_nxt;
  logic status_mode_r, status_mode_nxt;
  logic prog_err_r, prog_err_nxt;
  logic erase_err_r, erase_err_nxt;
  logic lock_res_r, lock_res_nxt;
  logic start_r, start_nxt;
  logic abort_r;
  logic nmi_s1_r, nmi_s2_r;
  logic [15:0] rom_rdata_r;
  logic [31:0] prdata_r;
  logic [CTRL_BITS-1:0] ctrl_q;

  //////////////////////////////////////////////////////////////////////
  // decode
  wire rewrite_enable = ctrl_q[0];
  wire lock_protect_disable = ctrl_q[1];
  wire rewrite_mode_select = ctrl_q[2];
  wire ram_mode = ~rewrite_mode_select;
  // odd addresses carry no commands
  wire wr_ev = rom_wr & ~rom_addr[0] & rewrite_enable; // see [R1]
  wire [7:0] code = rom_wdata[7:0]; // see [R1]
  wire abort = nmi_req | (wdt_req & ram_mode); // see [R17]
  wire busy = (state_r != ST_IDLE) && (state_r != ST_WAIT2);
  wire ready_w = ~busy; // see [R7]
  wire err_any = prog_err_r | erase_err_r;
  wire locked_eff = arr_locked & ~lock_protect_disable;
  wire guarded_cmd = (code == CMD_PROGRAM) || (code == CMD_BLK_ERASE) ||
                     (code == CMD_ERASE_ALL) || (code == CMD_LOCK_PROG);
  wire all_mode = (cmd_r == CMD_ERASE_ALL);
  wire show_status = status_mode_r | (busy & ram_mode);
  logic [7:0] status_byte;

  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_READY_BIT] = ready_w; // see [R24]
    status_byte[ST_EERR_BIT] = erase_err_r;
    status_byte[ST_PERR_BIT] = prog_err_r;
  end

  //////////////////////////////////////////////////////////////////////
  // apb: one wait-free access, read data captured in the setup cycle
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pwrite;
  wire hit_pri = (paddr == OFS_CTRL_PRI);
  wire hit_sec = (paddr == OFS_CTRL_SEC);
  logic [31:0] pri_w, sec_w;

  always_comb begin
    pri_w = 32'h0000_0000;
    pri_w[PRI_READY_BIT] = ready_w;
    pri_w[PRI_ENABLE_BIT] = rewrite_enable;
    pri_w[PRI_LOCKDIS_BIT] = lock_protect_disable;
    pri_w[PRI_PERR_BIT] = prog_err_r;
    pri_w[PRI_EERR_BIT] = erase_err_r;
    sec_w = 32'h0000_0000;
    sec_w[SEC_MODE_BIT] = rewrite_mode_select;
    sec_w[SEC_LOCKRES_BIT] = lock_res_r;
  end

  wire [31:0] rd_mux = hit_pri ? pri_w : hit_sec ? sec_w : 32'h0000_0000;
  wire [CTRL_BITS-1:0] wr_hit = {apb_wr & hit_sec, apb_wr & hit_pri,
                                 apb_wr & hit_pri};
  wire [CTRL_BITS-1:0] wbit = {pwdata[SEC_MODE_BIT],
                               pwdata[PRI_LOCKDIS_BIT],
                               pwdata[PRI_ENABLE_BIT]};

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(hit_pri | hit_sec);
  assign prdata = prdata_r;

  fcs_ctrl_bits u_ctrl (
    .pclk(pclk),
    .presetn(presetn),
    .any_wr(apb_wr),
    .wr_hit(wr_hit),
    .wbit(wbit),
    .intervene(irq_dma_event),
    .nmi_high(nmi_s2_r),
    .force_clr(abort),
    .q(ctrl_q)
  );

  //////////////////////////////////////////////////////////////////////
  // command state machine
  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    cmd_nxt = cmd_r;
    op_addr_nxt = op_addr_r;
    op_data_nxt = op_data_r;
    blk_nxt = blk_r;
    word_ok_nxt = word_ok_r;
    status_mode_nxt = status_mode_r;
    prog_err_nxt = prog_err_r;
    erase_err_nxt = erase_err_r;
    lock_res_nxt = lock_res_r;
    start_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (wr_ev) begin
          if (code == CMD_RD_ARRAY) begin
            status_mode_nxt = 1'b0; // see [R2]
          end else if (code == CMD_RD_STATUS) begin
            status_mode_nxt = 1'b1; // see [R3]
          end else if (code == CMD_CLR_STATUS) begin
            prog_err_nxt = 1'b0; // see [R5]
            erase_err_nxt = 1'b0;
          end else if (guarded_cmd && !err_any) begin // see [R25]
            cmd_nxt = code;
            op_addr_nxt = rom_addr;
            state_nxt = ST_WAIT2;
          end else if (code == CMD_LOCK_READ) begin
            cmd_nxt = code;
            status_mode_nxt = 1'b0; // see [R13]
            state_nxt = ST_WAIT2;
          end
        end
      end
      ST_WAIT2: begin
        if (wr_ev) begin
          state_nxt = ST_IDLE;
          if (cmd_r == CMD_PROGRAM) begin
            // program data may end in FFh, so it is never a read array
            if (rom_addr == op_addr_r) begin // see [R6]
              op_data_nxt = rom_wdata;
              kind_nxt = OP_PROGRAM;
              state_nxt = ST_CHECK;
            end else begin
              prog_err_nxt = 1'b1;
              erase_err_nxt = 1'b1;
            end
          end else if (code == CMD_RD_ARRAY) begin
            status_mode_nxt = 1'b0;
          end else if (code == CMD_CONFIRM) begin
            op_addr_nxt = rom_addr; // see [R11]
            state_nxt = ST_CHECK;
            if (cmd_r == CMD_BLK_ERASE || all_mode) begin
              kind_nxt = OP_ERASE;
            end else if (cmd_r == CMD_LOCK_PROG) begin
              kind_nxt = OP_LOCK_PROG; // see [R22]
            end else begin
              kind_nxt = OP_LOCK_READ; // see [R23]
            end
          end else begin
            // wrong second word: sequence error
            prog_err_nxt = 1'b1;
            erase_err_nxt = 1'b1;
          end
        end
      end
      ST_CHECK: begin
        // the array resolves the block of the target address
        blk_nxt = all_mode ? '0 : arr_addr_blk; // see [R14]
        word_ok_nxt = (arr_rdata == ERASED_WORD);
        state_nxt = ST_VERIFY;
      end
      ST_VERIFY: begin
        state_nxt = ST_RUN;
        start_nxt = 1'b1;
        status_mode_nxt = status_mode_r | ram_mode; // see [R10]
        if (kind_r == OP_PROGRAM && (locked_eff || !word_ok_r)) begin
          prog_err_nxt = 1'b1; // see [R9]
          start_nxt = 1'b0;
          state_nxt = ST_IDLE;
        end else if (kind_r == OP_ERASE && locked_eff) begin
          start_nxt = 1'b0;
          if (all_mode) begin
            state_nxt = ST_NEXT; // locked blocks are skipped
          end else begin
            erase_err_nxt = 1'b1;
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_RUN: begin
        if (arr_done) begin
          state_nxt = all_mode ? ST_NEXT : ST_IDLE;
          if (kind_r == OP_LOCK_READ) begin
            lock_res_nxt = arr_lock_bit; // see [R23]
          end else if (arr_fail && kind_r == OP_ERASE) begin
            erase_err_nxt = 1'b1; // see [R12]
          end else if (arr_fail) begin
            prog_err_nxt = 1'b1; // see [R8]
          end
          if (!all_mode && !ram_mode) begin
            status_mode_nxt = 1'b0;
          end
        end
      end
      ST_NEXT: begin
        if (blk_r == BLK_W'(LAST_ALL_BLK)) begin // see [R14]
          state_nxt = ST_IDLE;
          if (!ram_mode) begin
            status_mode_nxt = 1'b0;
          end
        end else begin
          blk_nxt = blk_r + BLK_W'(1);
          state_nxt = ST_VERIFY;
        end
      end
    endcase
    if (abort) begin
      state_nxt = ST_IDLE; // see [R17]
      status_mode_nxt = RST_STATUS_MODE;
      prog_err_nxt = RST_ERR;
      erase_err_nxt = RST_ERR;
      lock_res_nxt = RST_LOCK_RES;
      start_nxt = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      kind_r <= OP_PROGRAM;
      cmd_r <= 8'h00;
      op_addr_r <= '0;
      op_data_r <= 16'h0000;
      blk_r <= '0;
      word_ok_r <= 1'b0;
      status_mode_r <= RST_STATUS_MODE;
      prog_err_r <= RST_ERR;
      erase_err_r <= RST_ERR;
      lock_res_r <= RST_LOCK_RES;
      start_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      cmd_r <= cmd_nxt;
      op_addr_r <= op_addr_nxt;
      op_data_r <= op_data_nxt;
      blk_r <= blk_nxt;
      word_ok_r <= word_ok_nxt;
      status_mode_r <= status_mode_nxt;
      prog_err_r <= prog_err_nxt;
      erase_err_r <= erase_err_nxt;
      lock_res_r <= lock_res_nxt;
      start_r <= start_nxt;
      abort_r <= abort & busy;
    end
  end

  // nmi pin sampled through two stages before it may let an armed bit be set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_s1_r <= 1'b0;
      nmi_s2_r <= 1'b0;
    end else begin
      nmi_s1_r <= nmi_pin_n;
      nmi_s2_r <= nmi_s1_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rom_rdata_r <= 16'h0000;
      prdata_r <= 32'h0000_0000;
    end else begin
      if (rom_rd) begin
        rom_rdata_r <= show_status ? {8'h00, status_byte} : arr_rdata;
      end
      if (apb_setup) begin
        prdata_r <= rd_mux;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // array and cpu outputs; the address follows the cpu unless busy
  assign arr_addr = busy ? op_addr_r : rom_addr;
  assign arr_blk = blk_r;
  assign arr_start = start_r;
  assign arr_kind = kind_r;
  assign arr_wdata = op_data_r;
  assign arr_abort = abort_r;
  assign rom_rdata = rom_rdata_r;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire idle_cmd = (state_r == ST_IDLE) && wr_ev && !abort;

  a_start_busy: assert property ( // see [R7]
    start_r |-> !ready_w ##1 (!ready_w || arr_done || abort))
    else $error("ready high while an operation runs");
  a_clear_flags: assert property ( // see [R5]
    idle_cmd && code == CMD_CLR_STATUS |=> !prog_err_r && !erase_err_r)
    else $error("clear status left an error flag set");
  a_refuse_error: assert property ( // see [R25]
    idle_cmd && err_any && guarded_cmd |=> state_r == ST_IDLE)
    else $error("guarded command taken while an error is set");
  a_status_select: assert property ( // see [R3]
    idle_cmd && code == CMD_RD_STATUS |=> status_mode_r)
    else $error("read status did not select status mode");
  a_array_select: assert property ( // see [R2]
    idle_cmd && code == CMD_RD_ARRAY |=> !status_mode_r)
    else $error("read array did not leave status mode");
  a_prog_fail: assert property ( // see [R8]
    state_r == ST_RUN && arr_done && arr_fail && kind_r == OP_PROGRAM &&
    !abort |=> prog_err_r && ready_w)
    else $error("failed program not flagged");
  a_erase_fail: assert property ( // see [R12]
    state_r == ST_RUN && arr_done && arr_fail && kind_r == OP_ERASE &&
    !abort |=> erase_err_r)
    else $error("failed erase not flagged");
  a_abort_clear: assert property ( // see [R17]
    abort |=> state_r == ST_IDLE && !rewrite_enable && !err_any)
    else $error("abort did not clear the sequencer");
  a_status_upper: assert property ( // see [R26]
    rom_rd && show_status |=> rom_rdata[15:8] == 8'h00 &&
    rom_rdata[ST_READY_BIT] == $past(ready_w))
    else $error("status read shows wrong upper byte or ready");
  a_ram_status: assert property ( // see [R10]
    start_r && ram_mode |-> status_mode_r)
    else $error("ram mode start left array mode selected");
  a_erase_range: assert property ( // see [R14]
    start_r && all_mode |-> blk_r <= BLK_W'(LAST_ALL_BLK))
    else $error("erase all reached beyond the last block");
  a_used_word: assert property ( // see [R9]
    state_r == ST_VERIFY && kind_r == OP_PROGRAM && !word_ok_r |=>
    !start_r ##1 !start_r)
    else $error("programmed word was programmed again");

  c_program: cover property (start_r && kind_r == OP_PROGRAM);
  c_erase_all_end: cover property (state_r == ST_NEXT && all_mode &&
    blk_r == BLK_W'(LAST_ALL_BLK));
  c_lock_read: cover property (state_r == ST_RUN && arr_done &&
    kind_r == OP_LOCK_READ);
  c_abort_busy: cover property (abort && busy);
endmodule

// file: sim/fcs_array_model.sv
// Purpose: behavioural flash array facing the rewrite sequencer
// Assumes: 32 words per block, block index from address bits 9:6
// Notes: busy time and failure are steered by the bench
`timescale 1ns/1ps
module fcs_array_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sequencer side
  input wire logic [19:0] arr_addr,
  output logic [15:0] arr_rdata,
  output logic [3:0] arr_addr_blk,
  input wire logic [3:0] arr_blk,
  output logic arr_locked,
  input wire logic arr_start,
  input wire fcs_pkg::fcs_op_e arr_kind,
  input wire logic [15:0] arr_wdata,
  output logic arr_done,
  output logic arr_fail,
  output logic arr_lock_bit,
  input wire logic arr_abort,
  // bench controls
  input wire logic [7:0] busy_len,
  input wire logic fail_en
);
  import fcs_pkg::*;
  logic [15:0] mem [0:511];
  logic [15:0] lock_r;
  logic [7:0] cnt_r;
  fcs_op_e op_r;
  ////////////////////////////////////////////////////////////////////////////
  assign arr_addr_blk = arr_addr[9:6];
  assign arr_rdata = mem[arr_addr[9:1]];
  assign arr_locked = lock_r[arr_blk];
  assign arr_fail = arr_done & fail_en;
  // outside a done pulse the result line toggles, it is not held
  assign arr_lock_bit = arr_done ? ~lock_r[arr_blk] : cnt_r[0];
  initial begin
    lock_r = 16'h0000;
    for (int i = 0; i < 512; i++) mem[i] = ERASED_WORD;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      arr_done <= 1'b0;
    end else begin
      arr_done <= 1'b0;
      if (arr_start) begin
        cnt_r <= busy_len;
        op_r <= arr_kind;
      end else if (arr_abort) begin
        cnt_r <= 8'h00;
      end else if (cnt_r == 8'h01) begin
        cnt_r <= 8'h00;
        arr_done <= 1'b1;
        if (op_r == OP_PROGRAM) mem[arr_addr[9:1]] <= arr_wdata;
        if (op_r == OP_LOCK_PROG) lock_r[arr_blk] <= 1'b1;
        if (op_r == OP_ERASE && !fail_en) begin
          lock_r[arr_blk] <= 1'b0;
          for (int i = 0; i < 32; i++) begin
            mem[{arr_blk, i[4:0]}] <= ERASED_WORD;
          end
        end
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule

// file: sim/test_fcs_sequencer.sv
// Purpose: self-checking bench of the flash rewrite sequencer
// Assumes: cpu side driven as rom and apb tasks, array modelled
// Notes: block 0 top word at 3Eh, block 13 lies outside erase all
`timescale 1ns/1ps
module test_fcs_sequencer;
  import fcs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rom_wr, rom_rd, arr_locked, arr_start, arr_done, arr_fail;
  logic arr_lock_bit, arr_abort, nmi_req, wdt_req, irq_dma_event;
  logic nmi_pin_n, fail_en, abort_seen;
  logic [19:0] rom_addr, arr_addr;
  logic [15:0] rom_wdata, rom_rdata, arr_rdata, arr_wdata;
  logic [3:0] arr_addr_blk, arr_blk;
  logic [7:0] busy_len;
  fcs_op_e arr_kind;
  int err_total, checks;
  fcs_sequencer fcs_sequencer_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rom_wr, .rom_rd,
    .rom_addr, .rom_wdata, .rom_rdata, .arr_addr, .arr_rdata, .arr_addr_blk,
    .arr_blk, .arr_locked, .arr_start, .arr_kind, .arr_wdata, .arr_done,
    .arr_fail, .arr_lock_bit, .arr_abort, .nmi_req, .wdt_req,
    .irq_dma_event, .nmi_pin_n);
  fcs_array_model fcs_array_model_inst (.pclk, .presetn, .arr_addr,
    .arr_rdata, .arr_addr_blk, .arr_blk, .arr_locked, .arr_start, .arr_kind,
    .arr_wdata, .arr_done, .arr_fail, .arr_lock_bit, .arr_abort, .busy_len,
    .fail_en);
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) if (arr_abort === 1'b1) abort_seen <= 1'b1;
  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rw(input logic [19:0] a, input logic [15:0] d);
    @(posedge pclk);
    rom_wr <= 1'b1;
    rom_addr <= a;
    rom_wdata <= d;
    @(posedge pclk);
    rom_wr <= 1'b0;
  endtask
  task automatic rr(input logic [19:0] a, input logic [15:0] e);
    @(posedge pclk);
    rom_rd <= 1'b1;
    rom_addr <= a;
    @(posedge pclk);
    rom_rd <= 1'b0;
    #1 chk("rom_rdata", {16'h0000, rom_rdata}, {16'h0000, e});
  endtask
  task automatic pri(input logic [31:0] e);
    rd = 32'h0;
    // polls until the sequencer is ready, the watchdog bounds the wait
    while (rd[PRI_READY_BIT] !== 1'b1) apb(1'b0, OFS_CTRL_PRI, 32'h0);
    chk("ctrl_pri", rd, e);
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge pclk);
    err_total++;
    final_report();
  end
  initial begin
    {presetn, psel, penable, pwrite, rom_wr, rom_rd, nmi_req} = 7'h00;
    {wdt_req, irq_dma_event, fail_en, abort_seen} = 4'h0;
    {paddr, pwdata, rom_addr, rom_wdata} = 80'h0;
    nmi_pin_n = 1'b1;
    busy_len = 8'h05;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    pri(32'h0000_0001);
    apb(1'b0, 12'h008, 32'h0);
    chk("pslverr", {31'h0, serr}, 32'h1);
    // a dma event between the 0 and the 1 must cancel the arming
    apb(1'b1, OFS_CTRL_PRI, 32'h0);
    @(posedge pclk) irq_dma_event <= 1'b1;
    @(posedge pclk) irq_dma_event <= 1'b0;
    apb(1'b1, OFS_CTRL_PRI, 32'h2);
    pri(32'h0000_0001);
    apb(1'b1, OFS_CTRL_PRI, 32'h0);
    apb(1'b1, OFS_CTRL_PRI, 32'h2);
    pri(32'h0000_0003);
    rw(20'h10, 16'h55FF);
    rr(20'h10, ERASED_WORD);
    rr(20'h12, ERASED_WORD);
    rw(20'h10, 16'hAA70);
    rr(20'h20, 16'h0080);
    rw(20'h10, 16'h0040);
    rw(20'h10, 16'h1234);
    rr(20'h10, 16'h0000);
    pri(32'h0000_0003);
    rr(20'h10, 16'h0080);
    rw(20'h10, 16'h00FF);
    rr(20'h10, 16'h1234);
    rw(20'h10, 16'h0040);
    rw(20'h10, 16'h0000);
    pri(32'h0000_0043);
    rw(20'h20, 16'h0040);
    rw(20'h20, 16'h5555);
    rw(20'h20, 16'h00FF);
    rr(20'h20, ERASED_WORD);
    rw(20'h10, 16'h0050);
    pri(32'h0000_0003);
    rw(20'h10, 16'h0070);
    rr(20'h10, 16'h0080);
    fail_en <= 1'b1;
    rw(20'h20, 16'h0040);
    rw(20'h20, 16'h7777);
    pri(32'h0000_0043);
    rw(20'h3E, 16'h0050);
    rw(20'h3E, 16'h0020);
    rw(20'h3E, 16'h00D0);
    pri(32'h0000_0083);
    fail_en <= 1'b0;
    rw(20'h3E, 16'h0050);
    rw(20'h3E, 16'h0020);
    rw(20'h3E, 16'h00D0);
    pri(32'h0000_0003);
    rr(20'h10, 16'h0080);
    rw(20'h10, 16'h00FF);
    rr(20'h10, ERASED_WORD);
    rw(20'h310, 16'h0040);
    rw(20'h310, 16'h00AA);
    pri(32'h0000_0003);
    rw(20'h350, 16'h0040);
    rw(20'h350, 16'h00AA);
    pri(32'h0000_0003);
    rw(20'h10, 16'h00A7);
    rw(20'h10, 16'h00D0);
    pri(32'h0000_0003);
    rw(20'h10, 16'h00FF);
    rr(20'h310, ERASED_WORD);
    rr(20'h350, 16'h00AA);
    rw(20'h7E, 16'h0077);
    rw(20'h7E, 16'h00D0);
    pri(32'h0000_0003);
    rw(20'h7E, 16'h0071);
    rw(20'h7E, 16'h00D0);
    pri(32'h0000_0003);
    apb(1'b0, OFS_CTRL_SEC, 32'h0);
    chk("lock_state_result", rd, 32'h0);
    rw(20'h3E, 16'h0071);
    rw(20'h3E, 16'h00D0);
    pri(32'h0000_0003);
    apb(1'b0, OFS_CTRL_SEC, 32'h0);
    chk("lock_state_result", rd, 32'h40);
    // flash-executed mode: program data ending in FFh, back to array mode
    apb(1'b1, OFS_CTRL_SEC, 32'h0);
    apb(1'b1, OFS_CTRL_SEC, 32'h2);
    apb(1'b0, OFS_CTRL_SEC, 32'h0);
    chk("ctrl_sec", rd, 32'h42);
    rw(20'h24, 16'h0040);
    rw(20'h24, 16'h12FF);
    pri(32'h0000_0003);
    rr(20'h24, 16'h12FF);
    wdt_req <= 1'b1;
    @(posedge pclk) wdt_req <= 1'b0;
    pri(32'h0000_0003);
    busy_len <= 8'hC8;
    rw(20'h22, 16'h0040);
    rw(20'h22, 16'h9999);
    repeat (10) @(posedge pclk);
    nmi_req <= 1'b1;
    @(posedge pclk) nmi_req <= 1'b0;
    pri(32'h0000_0001);
    chk("arr_abort", {31'h0, abort_seen}, 32'h1);
    apb(1'b0, OFS_CTRL_SEC, 32'h0);
    chk("ctrl_sec", rd, 32'h0);
    final_report();
  end
endmodule
